// ---- pkg/sppmlc_pkg.sv ----
// constants and types of the serial port mode and line control block
package sppmlc_pkg;
    localparam int unsigned CLK_MHZ     = 250;
    localparam int unsigned BRK_GEN_MS  = 200;
    localparam int unsigned BRK_GEN_CYC = BRK_GEN_MS * 1000 * CLK_MHZ;
    localparam int unsigned BRK_DET_MS  = 150;
    localparam int unsigned BRK_DET_CYC = BRK_DET_MS * 1000 * CLK_MHZ;
    localparam int unsigned AW          = 4;
    localparam int unsigned DW          = 32;
    localparam logic [AW-1:0] CTRL_OFS  = 4'h0;
    localparam logic [AW-1:0] STAT_OFS  = 4'h4;
    localparam logic [AW-1:0] BCNT_OFS  = 4'h8;
    localparam int unsigned CTRL_MODE_LSB = 0;
    localparam int unsigned CTRL_PLOT_BIT = 2;
    localparam int unsigned NPIN   = 8;
    localparam int unsigned SI_CC  = 0;
    localparam int unsigned SI_CB  = 1;
    localparam int unsigned SI_MRX = 2;
    localparam int unsigned SI_TDT = 3;
    localparam int unsigned SI_TRT = 4;
    localparam int unsigned SI_TTX = 5;
    localparam int unsigned SI_BYP = 6;
    localparam int unsigned SI_HW  = 7;
    typedef enum logic [1:0] {
        MODE_STBY  = 2'b00,
        MODE_LOCAL = 2'b01,
        MODE_LINE  = 2'b10
    } sppmlc_mode_e;
    localparam sppmlc_mode_e MODE_RST = MODE_STBY;
    localparam logic       PLOT_RST  = 1'b0;
    localparam logic       MARK      = 1'b1;
    localparam logic [7:0] BCNT_RST  = 8'h00;
    localparam logic [NPIN-1:0] PIN_RST = 8'h24;
    // instruction codes: arbitrary values
    localparam logic [7:0] PLOT_ON_CODE  = 8'h01;
    localparam logic [7:0] PLOT_OFF_CODE = 8'h02;
endpackage : sppmlc_pkg

// ---- pkg/sppmlc_brk_if.sv ----
// signals between the line controller and the break relay
`timescale 1ns/100ps
`default_nettype none
interface sppmlc_brk_if;
    logic txd;
    logic arm;
    logic active;
    modport ctl (output txd, output arm, input active);
    modport gen (input txd, input arm, output active);
endinterface : sppmlc_brk_if
`default_nettype wire

// ---- src/sppmlc_sync.sv ----
// two-stage synchroniser for the pin inputs
`timescale 1ns/100ps
`default_nettype none
module sppmlc_sync #(
    parameter int unsigned  W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         i_clock,
    input  wire logic         i_sys_rst,
    input  wire logic [W-1:0] i_async,
    output var  logic [W-1:0] o_sync
);
    logic [W-1:0] meta_q;

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            meta_q <= RST_VAL;
            o_sync <= RST_VAL;
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule : sppmlc_sync
`default_nettype wire

// ---- src/sppmlc_brk.sv ----
// break detector on the terminal data line and timed break generator
`timescale 1ns/100ps
`default_nettype none
module sppmlc_brk #(
    parameter int unsigned DET_CYC = sppmlc_pkg::BRK_DET_CYC,
    parameter int unsigned GEN_CYC = sppmlc_pkg::BRK_GEN_CYC
) (
    input  wire logic   i_clock,
    input  wire logic   i_sys_rst,
    sppmlc_brk_if.gen   bi
);
    localparam int unsigned MAXC = (DET_CYC > GEN_CYC) ? DET_CYC : GEN_CYC;
    localparam int unsigned CW   = $clog2(MAXC + 1);
    localparam logic [CW-1:0] DET_LAST = CW'(DET_CYC - 1);
    localparam logic [CW-1:0] GEN_LAST = CW'(GEN_CYC - 1);

    typedef enum logic [1:0] {
        BK_IDLE = 2'b00,
        BK_LOW  = 2'b01,
        BK_GEN  = 2'b10,
        BK_WAIT = 2'b11
    } sppmlc_bk_e;

    sppmlc_bk_e    st_q, st_d;
    logic [CW-1:0] cnt_q, cnt_d;

    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_q + CW'(1);
        case (st_q)
            BK_IDLE: begin
                cnt_d = '0;
                if (bi.arm && !bi.txd) st_d = BK_LOW;
            end
            BK_LOW: begin
                if (bi.txd || !bi.arm) st_d = BK_IDLE;
                else if (cnt_q == DET_LAST) begin
                    st_d  = BK_GEN;
                    cnt_d = '0;
                end
            end
            BK_GEN: begin
                // leaving line mode ends the break at once
                if (!bi.arm) st_d = BK_IDLE;
                else if (cnt_q == GEN_LAST) st_d = BK_WAIT;
            end
            default: begin
                // one break per line-low period: wait for mark first
                cnt_d = '0;
                if (bi.txd || !bi.arm) st_d = BK_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st_q  <= BK_IDLE;
            cnt_q <= '0;
        end else begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
        end
    end

    assign bi.active = (st_q == BK_GEN); // RULE13

    brk_len_a: // RULE13
        assert property (@(posedge i_clock) disable iff (i_sys_rst)
            ($fell(bi.active) && $past(bi.arm)) |-> ($past(cnt_q) == GEN_LAST))
        else $error("break length differs from the generate count");
endmodule : sppmlc_brk
`default_nettype wire

// ---- src/sppmlc_top.sv ----
// mode-dependent modem and terminal line control with data routing
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// (RULE1) in line mode the block acts as terminal equipment toward the modem
// (RULE2) data lamp follows modem data set ready in every mode
// (RULE3) standby with normal switch: terminal ready high to modem, carrier to terminal
// (RULE4) local: modem ready, request and data low; modem inputs ignored; the data lamp still follows modem set ready
// (RULE5) local: terminal gets set ready and carrier high, clear follows request
// (RULE6) line: terminal ready to the modem held high; with the bypass switch it follows terminal ready instead
// (RULE7) line: request to send follows modem data set ready
// (RULE8) line: modem clear to send only counts while set ready is high
// (RULE9) line: modem data may go high only with set ready and clear high
// (RULE10) line: host data to plotter when on, to terminal when off
// (RULE11) line: terminal clear to send follows terminal request
// (RULE12) line: terminal set ready and carrier held high
// (RULE13) line: terminal break starts a 200 ms break toward the modem
// (RULE14) line: terminal data reaches host only while plotter output is idle
// (RULE15) line: host on/off instructions set the routing state
// (RULE16) bypass switch passes terminal ready straight to the modem; in local mode modem ready stays low instead
// (RULE17) standby relays via processor; local sends terminal data to plotter
// (RULE18) hardwire switch ignores modem clear to send and set ready; the data lamp still follows the unforced set ready
module sppmlc_top #(
    parameter int unsigned BRK_GEN_CYC   = sppmlc_pkg::BRK_GEN_CYC,
    parameter int unsigned BRK_DET_CYC   = sppmlc_pkg::BRK_DET_CYC,
    parameter logic [7:0]  PLOT_ON_CODE  = sppmlc_pkg::PLOT_ON_CODE,
    parameter logic [7:0]  PLOT_OFF_CODE = sppmlc_pkg::PLOT_OFF_CODE
) (
    input  wire logic                      i_clock,
    input  wire logic                      i_sys_rst,
    input  wire logic [sppmlc_pkg::AW-1:0] i_addr,
    input  wire logic [sppmlc_pkg::DW-1:0] i_wdata,
    input  wire logic                      i_wr,
    input  wire logic                      i_rd,
    output var  logic [sppmlc_pkg::DW-1:0] o_rdata,
    input  wire logic                      i_dtr_bypass,
    input  wire logic                      i_hardwire,
    input  wire logic                      i_mdm_dsr,
    input  wire logic                      i_mdm_cts,
    input  wire logic                      i_mdm_rxd,
    output var  logic                      o_mdm_dtr,
    output var  logic                      o_mdm_rts,
    output var  logic                      o_mdm_txd,
    input  wire logic                      i_trm_dtr,
    input  wire logic                      i_trm_rts,
    input  wire logic                      i_trm_txd,
    output var  logic                      o_trm_dsr,
    output var  logic                      o_trm_cts,
    output var  logic                      o_trm_dcd,
    output var  logic                      o_trm_rxd,
    output var  logic                      o_data_lamp,
    input  wire logic                      i_cpu_mdm_txd,
    input  wire logic                      i_cpu_trm_txd,
    input  wire logic                      i_cpu_tx_busy,
    output var  logic                      o_cpu_mdm_rxd,
    output var  logic                      o_cpu_trm_rxd,
    input  wire logic [7:0]                i_host_byte,
    input  wire logic                      i_host_valid,
    output var  logic                      o_plot_on
);
    localparam logic MARK = sppmlc_pkg::MARK;

    function automatic logic reg_hit(
        input logic [sppmlc_pkg::AW-1:0] a,
        input logic [sppmlc_pkg::AW-1:0] ofs
    );
        reg_hit = (a == ofs);
    endfunction : reg_hit

    // pins from the two ports and the switches
    logic [sppmlc_pkg::NPIN-1:0] pin_s;

    sppmlc_sync #(
        .W       (sppmlc_pkg::NPIN),
        .RST_VAL (sppmlc_pkg::PIN_RST)
    ) u_sync (
        .i_clock   (i_clock),
        .i_sys_rst (i_sys_rst),
        .i_async   ({i_hardwire, i_dtr_bypass, i_trm_txd, i_trm_rts,
                     i_trm_dtr, i_mdm_rxd, i_mdm_cts, i_mdm_dsr}),
        .o_sync    (pin_s)
    );

    wire cc_s     = pin_s[sppmlc_pkg::SI_CC];
    wire cb_s     = pin_s[sppmlc_pkg::SI_CB];
    wire mrxd_s   = pin_s[sppmlc_pkg::SI_MRX];
    wire tdtr_s   = pin_s[sppmlc_pkg::SI_TDT];
    wire trts_s   = pin_s[sppmlc_pkg::SI_TRT];
    wire ttxd_s   = pin_s[sppmlc_pkg::SI_TTX];
    wire bypass_s = pin_s[sppmlc_pkg::SI_BYP];
    wire hw_s     = pin_s[sppmlc_pkg::SI_HW];

    // software state
    sppmlc_pkg::sppmlc_mode_e mode_q, mode_d;
    logic                     plot_on_q, plot_on_d;
    logic [7:0]               bcnt_q, bcnt_d;
    logic [sppmlc_pkg::DW-1:0] rdata_d;

    wire is_stby  = (mode_q == sppmlc_pkg::MODE_STBY);
    wire is_local = (mode_q == sppmlc_pkg::MODE_LOCAL);
    wire is_line  = (mode_q == sppmlc_pkg::MODE_LINE);

    wire wr_ctrl = i_wr && reg_hit(i_addr, sppmlc_pkg::CTRL_OFS);
    wire wr_bcnt = i_wr && reg_hit(i_addr, sppmlc_pkg::BCNT_OFS);
    wire [1:0] wr_mode = i_wdata[sppmlc_pkg::CTRL_MODE_LSB +: 2];
    // the unused mode code is refused so the block never sits in no mode
    wire mode_ok = (wr_mode != 2'b11);

    assign mode_d = (wr_ctrl && mode_ok) ? sppmlc_pkg::sppmlc_mode_e'(wr_mode)
                                         : mode_q;

    // host byte scanner, only while on line
    wire scan_on  = is_line && i_host_valid && (i_host_byte == PLOT_ON_CODE);
    wire scan_off = is_line && i_host_valid && (i_host_byte == PLOT_OFF_CODE);

    // the scanner outranks a software write in the same cycle
    assign plot_on_d = scan_on  ? 1'b1 : // RULE15
                       scan_off ? 1'b0 : // RULE15
                       wr_ctrl  ? i_wdata[sppmlc_pkg::CTRL_PLOT_BIT] :
                                  plot_on_q;

    // break relay
    sppmlc_brk_if bk ();

    assign bk.txd = ttxd_s;
    assign bk.arm = is_line; // RULE13

    sppmlc_brk #(
        .DET_CYC (BRK_DET_CYC),
        .GEN_CYC (BRK_GEN_CYC)
    ) u_brk (
        .i_clock   (i_clock),
        .i_sys_rst (i_sys_rst),
        .bi        (bk.gen)
    );

    logic brk_q;
    wire  brk_rise = bk.active && !brk_q;

    // counter of relayed breaks; a new break wins over a clear
    assign bcnt_d = brk_rise ? bcnt_q + 8'h01 :
                    wr_bcnt  ? sppmlc_pkg::BCNT_RST :
                               bcnt_q;

    // modem handshake as seen after the hardwire switch
    wire cc_eff = hw_s | cc_s;       // RULE18
    wire cb_eff = hw_s | cb_s;       // RULE18
    wire cb_mon = cc_eff & cb_eff;   // RULE8

    // terminal data only while the plotter sender is idle
    wire fwd      = is_line && !i_cpu_tx_busy;          // RULE14
    wire line_src = fwd ? ttxd_s : i_cpu_mdm_txd;       // RULE14

    // modem side: the block plays terminal equipment on line
    wire gen_dtr     = !is_local;                        // RULE1 RULE3 RULE6
    wire mdm_dtr_d   = is_local ? 1'b0 :                 // RULE4
                       bypass_s ? tdtr_s : gen_dtr;      // RULE16
    wire mdm_rts_d   = is_local ? 1'b0 : cc_eff;         // RULE4 RULE7
    wire line_txd    = line_src & cb_mon & !bk.active;   // RULE9 RULE13
    wire mdm_txd_d   = is_local ? 1'b0 :                 // RULE4
                       is_line  ? line_txd :
                                  i_cpu_mdm_txd;         // RULE17

    // terminal side
    wire trm_dsr_d   = is_stby ? cc_eff : 1'b1;          // RULE5 RULE12
    wire trm_cts_d   = is_stby ? cb_eff : trts_s;        // RULE5 RULE11
    wire trm_dcd_d   = 1'b1;                             // RULE3 RULE5 RULE12
    wire trm_rxd_d   = is_line ? (plot_on_q ? MARK : mrxd_s) // RULE10
                               : i_cpu_trm_txd;          // RULE17

    // toward the plotter's own receivers
    wire cpu_mdm_rxd_d = (is_local || (is_line && !plot_on_q)) ? MARK // RULE4
                                                               : mrxd_s; // RULE10
    wire cpu_trm_rxd_d = is_line ? MARK : ttxd_s;        // RULE17

    wire lamp_d = cc_s; // RULE2

    // register read, data only in the cycle after the strobe
    wire [sppmlc_pkg::DW-1:0] ctrl_rd = {29'h0, plot_on_q, mode_q};
    wire [sppmlc_pkg::DW-1:0] stat_rd = {22'h0, bk.active, plot_on_q, pin_s};
    wire [sppmlc_pkg::DW-1:0] bcnt_rd = {24'h0, bcnt_q};

    assign rdata_d = !i_rd                                ? '0 :
                     reg_hit(i_addr, sppmlc_pkg::CTRL_OFS) ? ctrl_rd :
                     reg_hit(i_addr, sppmlc_pkg::STAT_OFS) ? stat_rd :
                     reg_hit(i_addr, sppmlc_pkg::BCNT_OFS) ? bcnt_rd :
                                                             '0;

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            mode_q    <= sppmlc_pkg::MODE_RST;
            plot_on_q <= sppmlc_pkg::PLOT_RST;
            bcnt_q    <= sppmlc_pkg::BCNT_RST;
            brk_q     <= 1'b0;
            o_rdata   <= '0;
        end else begin
            mode_q    <= mode_d;
            plot_on_q <= plot_on_d;
            bcnt_q    <= bcnt_d;
            brk_q     <= bk.active;
            o_rdata   <= rdata_d;
        end
    end

    // all line outputs are registered so no decode glitch reaches a pin
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_mdm_dtr     <= 1'b0;
            o_mdm_rts     <= 1'b0;
            o_mdm_txd     <= MARK;
            o_trm_dsr     <= 1'b0;
            o_trm_cts     <= 1'b0;
            o_trm_dcd     <= 1'b0;
            o_trm_rxd     <= MARK;
            o_data_lamp   <= 1'b0;
            o_cpu_mdm_rxd <= MARK;
            o_cpu_trm_rxd <= MARK;
            o_plot_on     <= sppmlc_pkg::PLOT_RST;
        end else begin
            o_mdm_dtr     <= mdm_dtr_d;
            o_mdm_rts     <= mdm_rts_d;
            o_mdm_txd     <= mdm_txd_d;
            o_trm_dsr     <= trm_dsr_d;
            o_trm_cts     <= trm_cts_d;
            o_trm_dcd     <= trm_dcd_d;
            o_trm_rxd     <= trm_rxd_d;
            o_data_lamp   <= lamp_d;
            o_cpu_mdm_rxd <= cpu_mdm_rxd_d;
            o_cpu_trm_rxd <= cpu_trm_rxd_d;
            o_plot_on     <= plot_on_d;
        end
    end

    default clocking cb_clk @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);

    lamp_follow_a: // RULE2
        assert property (##1 o_data_lamp == $past(cc_s))
        else $error("data lamp does not follow set ready");

    // the release edge still samples reset high; outputs only move one edge later
    stby_dtr_a: // RULE3
        assert property ((!i_sys_rst && is_stby && !bypass_s) |=> (o_mdm_dtr && o_trm_dcd))
        else $error("standby ready or carrier low");

    local_mdm_a: // RULE4
        assert property (is_local |=> (!o_mdm_dtr && !o_mdm_rts && !o_mdm_txd))
        else $error("modem lines not low in local mode");

    local_trm_a: // RULE5
        assert property (is_local |=>
            (o_trm_dsr && o_trm_dcd && (o_trm_cts == $past(trts_s))))
        else $error("terminal lines wrong in local mode");

    line_dtr_a: // RULE6
        assert property ((is_line && !bypass_s) |=> o_mdm_dtr)
        else $error("terminal ready low on line");

    line_rts_a: // RULE7
        assert property (is_line |=> (o_mdm_rts == $past(cc_eff)))
        else $error("request to send does not follow set ready");

    line_txd_a: // RULE9
        assert property ((is_line ##1 o_mdm_txd) |-> $past(cc_eff && cb_eff))
        else $error("modem data high without set ready and clear");

    line_rx_a: // RULE10
        assert property ((is_line && plot_on_q) |=>
            (o_cpu_mdm_rxd == $past(mrxd_s) && o_trm_rxd))
        else $error("host data not routed to plotter");

    line_trm_a: // RULE11
        assert property (is_line |=>
            (o_trm_dsr && o_trm_dcd && (o_trm_cts == $past(trts_s))))
        else $error("terminal lines wrong on line");

    brk_hold_a: // RULE13
        assert property ((is_line && bk.active) |=> !o_mdm_txd)
        else $error("modem data not held in break");

    fwd_gate_a: // RULE14
        assert property ((is_line && i_cpu_tx_busy && !bk.active) |=>
            (o_mdm_txd == $past(i_cpu_mdm_txd && cb_mon)))
        else $error("terminal data broke into plotter output");

    scan_on_a: // RULE15
        assert property (scan_on |=> (plot_on_q && o_plot_on) [*2])
        else $error("plotter-on instruction not taken");

    bypass_dtr_a: // RULE16
        assert property ((bypass_s && !is_local) |=> (o_mdm_dtr == $past(tdtr_s)))
        else $error("bypass does not pass terminal ready");

    hardwire_a: // RULE18
        assert property ((is_line && hw_s) |=> o_mdm_rts)
        else $error("hardwire does not ignore set ready");
endmodule : sppmlc_top
`default_nettype wire

// ---- testbench/sppmlc_far_model.sv ----
// behavioural modem at the far side of the modem port
`timescale 1ns/100ps
`default_nettype none
module sppmlc_far_model (
    input  wire logic       i_clock,
    input  wire logic       i_sys_rst,
    input  wire logic       i_dsr_on,
    input  wire logic       i_cts_hold,
    input  wire logic [1:0] i_lag,
    input  wire logic       i_rxd_bit,
    input  wire logic       i_rts,
    output var  logic       o_dsr,
    output var  logic       o_cts,
    output var  logic       o_rxd
);
    logic [3:0] rts_q;
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rts_q <= 4'h0;
        end else begin
            rts_q <= {rts_q[2:0], i_rts};
        end
    end
    // a slow modem grants later; a held modem never grants, so both answers get exercised
    assign o_cts = rts_q[i_lag] & ~i_cts_hold & i_dsr_on;
    assign o_dsr = i_dsr_on;
    // an idle modem line rests at mark
    assign o_rxd = i_rxd_bit;
endmodule : sppmlc_far_model
`default_nettype wire

// ---- testbench/tb_sppmlc_top.sv ----
// self-checking bench of the serial port mode and line control block
`timescale 1ns/100ps
`default_nettype none
module tb_sppmlc_top;
    localparam int unsigned GEN = 20;
    localparam int unsigned DET = 10;
    logic        i_clock = 1'b0, i_sys_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
    logic [3:0]  i_addr = 4'h0;
    logic [31:0] i_wdata = 32'h0, o_rdata, seed = 32'hc300;
    logic        byp = 1'b0, hw = 1'b0, dsr_on = 1'b0, cts_hold = 1'b0, rxd = 1'b1;
    logic        tdtr = 1'b0, trts = 1'b0, ttxd = 1'b1, cmtx = 1'b1, cttx = 1'b1;
    logic        busy = 1'b0, hvalid = 1'b0, plot;
    logic [7:0]  hbyte = 8'h00;
    logic [1:0]  lag = 2'h0, mode;
    logic        mdsr, mcts, mrxd, odtr, orts, otxd, tdsr, tcts, tdcd, trxd, lamp;
    logic        cmrx, ctrx, pon;
    logic [9:0]  got, ex;
    int          fails = 0, cmp_count = 0, n, cnt;

    always #2 i_clock = ~i_clock;
    assign got = {odtr, orts, otxd, tdsr, tcts, tdcd, trxd, lamp, cmrx, ctrx};

    sppmlc_top #(.BRK_GEN_CYC(GEN), .BRK_DET_CYC(DET)) dut_u (
        .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_dtr_bypass(byp), .i_hardwire(hw),
        .i_mdm_dsr(mdsr), .i_mdm_cts(mcts), .i_mdm_rxd(mrxd), .o_mdm_dtr(odtr),
        .o_mdm_rts(orts), .o_mdm_txd(otxd), .i_trm_dtr(tdtr), .i_trm_rts(trts),
        .i_trm_txd(ttxd), .o_trm_dsr(tdsr), .o_trm_cts(tcts), .o_trm_dcd(tdcd),
        .o_trm_rxd(trxd), .o_data_lamp(lamp), .i_cpu_mdm_txd(cmtx), .i_cpu_trm_txd(cttx),
        .i_cpu_tx_busy(busy), .o_cpu_mdm_rxd(cmrx), .o_cpu_trm_rxd(ctrx),
        .i_host_byte(hbyte), .i_host_valid(hvalid), .o_plot_on(pon));

    sppmlc_far_model far_u (
        .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_dsr_on(dsr_on), .i_cts_hold(cts_hold),
        .i_lag(lag), .i_rxd_bit(rxd), .i_rts(orts), .o_dsr(mdsr), .o_cts(mcts), .o_rxd(mrxd));

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    // order: dtr rts txd | trm dsr cts dcd rxd | lamp cpu_mdm_rxd cpu_trm_rxd
    function automatic logic [9:0] exp_pins(input logic [1:0] m, input logic p);
        logic de, ce, d;
        de = hw | mdsr;
        ce = hw | mcts;
        d = byp ? tdtr : 1'b1;
        if (m == 2'b01) begin
            return {3'b000, 1'b1, trts, 1'b1, cttx, mdsr, 1'b1, ttxd};
        end
        if (m == 2'b10) begin
            return {d, de, (busy ? cmtx : ttxd) & de & ce, 1'b1, trts, 1'b1,
                    p ? 1'b1 : mrxd, mdsr, p ? mrxd : 1'b1, 1'b1};
        end
        return {d, de, cmtx, de, ce, 1'b1, cttx, mdsr, mrxd, ttxd};
    endfunction : exp_pins

    task automatic chk_pins(input string nm, input logic [9:0] e, input logic [9:0] k);
        cmp_count++;
        if ((got & k) !== (e & k)) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e & k, got & k);
        end
    endtask : chk_pins

    task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_word

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clock);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [31:0] e, input string nm);
        @(posedge i_clock);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1;
        chk_word(nm, e, o_rdata);
    endtask : rd

    task automatic host(input logic [7:0] b, input logic e);
        @(posedge i_clock);
        hbyte <= b;
        hvalid <= 1'b1;
        @(posedge i_clock);
        hvalid <= 1'b0;
        @(posedge i_clock);
        #1;
        chk_word("plot_on", {31'h0, e}, {31'h0, pon});
    endtask : host

    task automatic stop_test;
        if (fails == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test

    initial begin
        repeat (100000) @(posedge i_clock);
        fails++;
        stop_test();
    end

    initial begin
        repeat (10) @(posedge i_clock);
        #1;
        chk_pins("reset_pins", 10'h08b, 10'h3ff);
        repeat (10) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        for (n = 0; n < 40; n++) begin
            seed = xs(seed);
            mode = (seed[1:0] == 2'b11) ? 2'b10 : seed[1:0];
            plot = seed[2];
            @(posedge i_clock);
            {byp, hw, dsr_on, cts_hold} <= seed[6:3];
            {lag, rxd, tdtr, trts} <= seed[11:7];
            // a long low on terminal data in line mode would start a break
            ttxd <= (mode == 2'b10) | seed[12];
            {cmtx, cttx, busy} <= seed[15:13];
            wr(sppmlc_pkg::CTRL_OFS, {29'h0, plot, mode});
            repeat (16) @(posedge i_clock);
            #1;
            ex = exp_pins(mode, plot);
            chk_pins("mdm_ctl", ex, 10'h300);
            chk_pins("mdm_txd", ex, 10'h080);
            chk_pins("trm_pins", ex, 10'h07f);
            rd(sppmlc_pkg::CTRL_OFS, {29'h0, plot, mode}, "ctrl");
        end
        // idle the terminal line first, or entering line mode could start a break
        @(posedge i_clock);
        ttxd <= 1'b1;
        wr(sppmlc_pkg::CTRL_OFS, 32'h2);
        host(sppmlc_pkg::PLOT_ON_CODE, 1'b1);
        host(8'h55, 1'b1);
        host(sppmlc_pkg::PLOT_OFF_CODE, 1'b0);
        host(sppmlc_pkg::PLOT_ON_CODE, 1'b1);
        wr(sppmlc_pkg::CTRL_OFS, 32'h0);
        host(sppmlc_pkg::PLOT_ON_CODE, 1'b0);
        wr(sppmlc_pkg::STAT_OFS, 32'hffff_ffff);
        wr(sppmlc_pkg::CTRL_OFS, 32'h7);
        rd(sppmlc_pkg::CTRL_OFS, 32'h4, "ctrl_refused");
        rd(4'hc, 32'h0, "unmapped");
        @(posedge i_clock);
        // modem ready and clear, so the line can return to mark after the break
        {byp, hw, dsr_on, cts_hold, busy, ttxd} <= 6'h29;
        wr(sppmlc_pkg::CTRL_OFS, 32'h2);
        repeat (16) @(posedge i_clock);
        ttxd <= 1'b0;
        repeat (DET - 3) @(posedge i_clock);
        ttxd <= 1'b1;
        repeat (10) @(posedge i_clock);
        rd(sppmlc_pkg::BCNT_OFS, 32'h0, "short_low");
        @(posedge i_clock);
        ttxd <= 1'b0;
        repeat (DET + 4) @(posedge i_clock);
        ttxd <= 1'b1;
        cnt = 0;
        // bounded: a break that never ends shows as an overlong run
        while (cnt < 100) begin
            @(posedge i_clock);
            #1;
            if (otxd === 1'b1) begin
                break;
            end
            cnt++;
        end
        chk_word("break_len", 32'h1, {31'h0, cnt >= GEN - 8 && cnt <= GEN});
        rd(sppmlc_pkg::BCNT_OFS, 32'h1, "break_count");
        rd(sppmlc_pkg::STAT_OFS, {24'h0, hw, byp, ttxd, trts, tdtr, mrxd, mcts, mdsr}, "status");
        wr(sppmlc_pkg::BCNT_OFS, 32'h0);
        rd(sppmlc_pkg::BCNT_OFS, 32'h0, "break_clear");
        stop_test();
    end
endmodule : tb_sppmlc_top
`default_nettype wire
